// ---- logic/pcr_defines.vh ----
// peak code recorder: register offsets, field positions and reset values
// assumes inclusion by bare name from the recorder module only
`ifndef PCR_DEFINES_VH
`define PCR_DEFINES_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define PCR_PEAK_BASE        8'h60
`define PCR_PEAK_CH3_HIGH    8'h67
`define PCR_PEAK_CH4_LOW     8'h68
`define PCR_PEAK_CH4_HIGH    8'h69
`define PCR_PEAK_CH5_LOW     8'h6A
`define PCR_PEAK_CH5_HIGH    8'h6B
`define PCR_PEAK_CH6_LOW     8'h6C
`define PCR_PEAK_CH6_HIGH    8'h6D
`define PCR_PEAK_CH7_LOW     8'h6E
`define PCR_MAP_FIRST        `PCR_PEAK_CH3_HIGH
`define PCR_MAP_LAST         `PCR_PEAK_CH7_LOW

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define PCR_LOW_MSB          7
`define PCR_LOW_LSB          0
`define PCR_HIGH_MSB         15
`define PCR_HIGH_LSB         8
`define PCR_PEAK_RESET       16'h0000
`define PCR_RDATA_RESET      8'h00
`define PCR_UNMAPPED_DATA    8'h00

`endif

// ---- logic/pcr_peak_recorder.v ----
// peak code recorder: read-clear largest-code registers per channel
// assumes conversion results arrive as one-cycle strobes synchronous to
// CLK, and a plain register port with read data one cycle after strobe
//
// How it works
// - per channel hold largest code since read
// - read at 0x67..0x6E returns value, then clears that byte
// - after reset every peak reads zero
// - low byte even, high byte odd address
// - channel 3 high byte at 0x67
`timescale 1ns/1ps
`include "pcr_defines.vh"

module pcr_peak_recorder
#(
  parameter CODE_W   = 16,
  parameter FIRST_CH = 3,
  parameter LAST_CH  = 7
)
(
  // clock and reset
  input  wire        CLK,
  input  wire        RESETN,
  // conversion results
  input  wire        CONV_VALID,
  input  wire [2:0]  CONV_CHAN,
  input  wire [CODE_W-1:0] CONV_CODE,
  // register port
  input  wire [7:0]  ADDR,
  input  wire [7:0]  WDATA,
  input  wire        WR_STB,
  input  wire        RD_STB,
  output wire [7:0]  RDATA
);

  localparam NCH = LAST_CH - FIRST_CH + 1;

  reg  [7:0]        rdata_ff;
  reg  [7:0]        nxt_rdata;
  wire [NCH*8-1:0]  lo_bytes;
  wire [NCH*8-1:0]  hi_bytes;
  wire [NCH-1:0]    lo_hit;
  wire [NCH-1:0]    hi_hit;
  wire              in_map;

  // ---------------------------------------------------------------
  // address window
  // ---------------------------------------------------------------
  // bytes outside the window (channel 3 low, channel 7 high) are not
  // decoded here; they belong to the neighbouring register block
  assign in_map = (ADDR >= `PCR_MAP_FIRST) && (ADDR <= `PCR_MAP_LAST);

  // ---------------------------------------------------------------
  // per channel peak storage
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : gen_ch
      // integer sums are cut to the address and channel widths on purpose
      localparam integer LO_NUM  = `PCR_PEAK_BASE + 2 * (FIRST_CH + g);
      localparam integer CH_NUM  = FIRST_CH + g;
      localparam [7:0]   LO_ADDR = LO_NUM[7:0];
      localparam [7:0]   HI_ADDR = LO_ADDR + 8'h01;
      localparam [2:0]   CH_ID   = CH_NUM[2:0];

      reg  [CODE_W-1:0] peak_ff;
      reg  [CODE_W-1:0] nxt_peak;
      reg  [CODE_W-1:0] cleared;
      wire        conv_hit;

      assign lo_hit[g] = in_map && (ADDR == LO_ADDR);
      assign hi_hit[g] = in_map && (ADDR == HI_ADDR);
      assign conv_hit  = CONV_VALID && (CONV_CHAN == CH_ID);

      assign lo_bytes[g*8 +: 8] = peak_ff[`PCR_LOW_MSB:`PCR_LOW_LSB];
      assign hi_bytes[g*8 +: 8] = peak_ff[`PCR_HIGH_MSB:`PCR_HIGH_LSB];

      always @*
      begin
        cleared = peak_ff;
        if (RD_STB && lo_hit[g])
        begin
          cleared[`PCR_LOW_MSB:`PCR_LOW_LSB] = 8'h00;
        end
        if (RD_STB && hi_hit[g])
        begin
          cleared[`PCR_HIGH_MSB:`PCR_HIGH_LSB] = 8'h00;
        end
        nxt_peak = cleared;
        // strictly greater wins
        // compared against the cleared value so a code arriving with the
        // read is kept and tracking restarts from it
        if (conv_hit && (CONV_CODE > cleared))
        begin
          nxt_peak = CONV_CODE;
        end
      end

      always @(posedge CLK or negedge RESETN)
      begin
        if (!RESETN)
        begin
          peak_ff <= `PCR_PEAK_RESET;
        end
        else
        begin
          peak_ff <= nxt_peak;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // read data path
  // ---------------------------------------------------------------
  integer i;
  always @*
  begin
    nxt_rdata = `PCR_UNMAPPED_DATA;
    if (RD_STB)
    begin
      for (i = 0; i < NCH; i = i + 1)
      begin
        if (hi_hit[i])
        begin
          nxt_rdata = hi_bytes[i*8 +: 8];
        end
        if (lo_hit[i])
        begin
          nxt_rdata = lo_bytes[i*8 +: 8];
        end
      end
    end
  end

  // writes are ignored: every byte here is read-only
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rdata_ff <= `PCR_RDATA_RESET;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign RDATA = rdata_ff;

endmodule

// ---- verification/pcr_peak_chk.sv ----
// checker for the peak recorder ports
// assumes binding onto pcr_peak_recorder
`timescale 1ns/1ps
module pcr_peak_chk (
  input wire        CLK, RESETN, CONV_VALID, RD_STB,
  input wire [2:0]  CONV_CHAN,
  input wire [15:0] CONV_CODE,
  input wire [7:0]  ADDR, RDATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  wire r69 = RD_STB && ADDR == 8'h69;
  wire r67 = RD_STB && ADDR == 8'h67;
  wire cv = CONV_VALID && CONV_CODE[15:8] != 8'h00 && !RD_STB;
  AST_RESET: assert property (
    $rose(RESETN) |-> RDATA == 8'h00) else $error("rdata after reset");
  AST_MAP: assert property (
    RD_STB && (ADDR < 8'h67 || ADDR > 8'h6E) |=> RDATA == 8'h00)
    else $error("unmapped read");
  AST_CLEAR: assert property (
    RD_STB && !CONV_VALID ##1 RD_STB && $stable(ADDR) |=> RDATA == 8'h00)
    else $error("no clear");
  AST_GROW: assert property (
    r69 && !CONV_VALID ##1 cv && CONV_CHAN == 3'h4 ##1 r69
    |=> RDATA == $past(CONV_CODE[15:8], 2)) else $error("no peak");
  AST_KEEP: assert property (
    r69 && !CONV_VALID ##1 cv && CONV_CHAN == 3'h4 ##1 cv
    && CONV_CHAN == 3'h4 && CONV_CODE <= $past(CONV_CODE) ##1 r69
    |=> RDATA == $past(CONV_CODE[15:8], 3)) else $error("peak lost");
  AST_CH3: assert property (
    r67 && !CONV_VALID ##1 cv && CONV_CHAN == 3'h3 ##1 r67
    |=> RDATA == $past(CONV_CODE[15:8], 2)) else $error("ch3 high");
endmodule
bind pcr_peak_recorder pcr_peak_chk u_chk (.CLK(CLK), .RESETN(RESETN),
  .CONV_VALID(CONV_VALID), .RD_STB(RD_STB), .CONV_CHAN(CONV_CHAN),
  .CONV_CODE(CONV_CODE), .ADDR(ADDR), .RDATA(RDATA));

// ---- verification/pcr_peak_recorder_bench.sv ----
// bench for the peak recorder
// assumes design and checker compiled with it
`timescale 1ns/1ps
module pcr_peak_recorder_bench;
  reg        CLK = 0, RESETN = 0, CONV_VALID = 0, WR_STB = 0, RD_STB = 0;
  reg [2:0]  CONV_CHAN = 3'h0;
  reg [15:0] CONV_CODE = 16'h0000;
  reg [7:0]  ADDR = 8'h00, WDATA = 8'hFF;
  reg        chk_on = 1'b0;
  reg [7:0]  chk_val = 8'h00;
  wire [7:0] RDATA;
  integer    failures = 0, checks_done = 0, i;
  always #50 CLK = ~CLK;
  pcr_peak_recorder uut (.CLK(CLK), .RESETN(RESETN), .CONV_VALID(CONV_VALID),
    .CONV_CHAN(CONV_CHAN), .CONV_CODE(CONV_CODE), .ADDR(ADDR),
    .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA));
  // one cycle of stimulus set at an edge; a read is judged mid next cycle
  task step(input r, input w, input [7:0] a, input [7:0] e, input v,
    input [2:0] c, input [15:0] d);
  begin
    RD_STB <= r;
    WR_STB <= w;
    ADDR <= a;
    CONV_VALID <= v;
    CONV_CHAN <= c;
    CONV_CODE <= d;
    @(posedge CLK);
    chk_on <= r;
    chk_val <= e;
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    step(1'b1, 1'b0, a, e, 1'b0, 3'h0, 16'h0000);
  endtask
  task cv(input [2:0] c, input [15:0] d);
    step(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, c, d);
  endtask
  task idle;
    step(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 3'h0, 16'h0000);
  endtask
  always @(negedge CLK)
    if (chk_on)
    begin
      checks_done = checks_done + 1;
      if (RDATA !== chk_val)
      begin
        failures = failures + 1;
        $display("unexpected at %0t: %h not %h", $time, RDATA, chk_val);
      end
    end
  task t_ch4;
  begin
    rd(8'h69, 8'h00);
    cv(3'h4, 16'h0ABC);
    rd(8'h69, 8'h0A);
    rd(8'h69, 8'h00);
    cv(3'h4, 16'h0BCD);
    cv(3'h4, 16'h0B00);
    rd(8'h69, 8'h0B);
    rd(8'h68, 8'hCD);
    rd(8'h68, 8'h00);
    cv(3'h4, 16'h0100);
    step(1'b1, 1'b0, 8'h69, 8'h01, 1'b1, 3'h4, 16'h0200);
    rd(8'h69, 8'h02);
  end
  endtask
  task t_rest;
  begin
    rd(8'h67, 8'h00);
    cv(3'h3, 16'h1234);
    rd(8'h67, 8'h12);
    rd(8'h66, 8'h00);
    cv(3'h2, 16'hFFFF);
    rd(8'h64, 8'h00);
    for (i = 5; i < 8; i = i + 1)
      cv(i[2:0], {5'h00, i[2:0], 8'hA0 | i[7:0]});
    // writes have no effect on a held peak
    step(1'b0, 1'b1, 8'h6A, 8'h00, 1'b0, 3'h0, 16'h0000);
    for (i = 5; i < 8; i = i + 1)
    begin
      rd({i[6:0], 1'b0} | 8'h60, 8'hA0 | i[7:0]);
      rd({i[6:0], 1'b1} | 8'h60, i < 7 ? i[7:0] : 8'h00);
    end
  end
  endtask
  task t_reset;
  begin
    cv(3'h5, 16'h0F00);
    RESETN <= 1'b0;
    @(posedge CLK);
    RESETN <= 1'b1;
    rd(8'h6B, 8'h00);
    rd(8'h6A, 8'h00);
  end
  endtask
  task wrap_up;
  begin
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    repeat (5) @(posedge CLK);
    RESETN <= 1'b1;
    t_ch4;
    t_rest;
    t_reset;
    idle;
    wrap_up;
  end
endmodule
